// ### logic/sysrc_ctrl.sv
// Notes on behaviour
// - peripheral pwm clock is the system clock divided by 1,2,4,...,64
// - divider setting reads back as the last legal code written
// - pwm clock is always a fixed fraction of the system clock
// - software reset resets processor, peripherals and all registers except the cause record to defaults; interrupt status is left holding only the software bit
// - software reset keeps the cause record but adds the software bit
// - six cause bits, read together as one word
// - cause bits stick until cleared by software or an external reset
// - clearing a subset clears only those bits; later resets set them again
// - automatic gating in sleep keeps only sleep-marked peripherals clocked, they wake
// - without automatic gating, sleep leaves every enabled peripheral clocked
// - usb pll power-down stops the phy; usb registers stay reachable
// - sram size in bytes is readable
// - sleep marking is kept but ignored while automatic gating is off
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module sysrc_ctrl #(
    parameter int N_PERIPH = 32,
    parameter logic [31:0] SRAM_BYTES = 32'h00010000
) (
    // clock and power-on reset
    input wire logic CLOCK,
    input wire logic SRST,
    // axi4-lite write
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [7:0] AWADDR,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // axi4-lite read
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [7:0] ARADDR,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    // reset sources from pins and analog monitors
    input wire logic RST_EXT_PIN,
    input wire logic RST_BROWN_OUT,
    input wire logic RST_WATCHDOG,
    input wire logic RST_REG_FAULT,
    // processor and peripherals
    input wire logic CPU_SLEEP,
    input wire logic [N_PERIPH-1:0] PERIPH_IRQ,
    output logic [N_PERIPH-1:0] PERIPH_CLK_EN,
    output logic WAKE_REQ,
    output logic SYS_RST_OUT,
    output logic PWM_CLK_EN,
    output logic USB_PLL_PWR,
    output logic IRQ
);
    // run and sleep enables each live in one 32-bit register word
    if (N_PERIPH < 1 || N_PERIPH > 32) begin : g_periph_check
        $error("N_PERIPH must be 1..32");
    end

    localparam int N_CAUSE_W = sysrc_pkg::N_CAUSES;
    logic [3:0] src_a_r, src_b_r, src_c_r, src_a_nxt, src_b_nxt, src_c_nxt;
    logic [N_CAUSE_W-1:0] ev;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [2:0] pwmdiv_r, pwmdiv_nxt, sel_r, sel_nxt;
    logic [5:0] cnt_r, cnt_nxt, mask6;
    logic tick;
    logic [5:0] cause_r, cause_nxt, istat_r, istat_nxt, imask_r, imask_nxt;
    logic [N_PERIPH-1:0] runen_r, runen_nxt, slpen_r, slpen_nxt, clken_nxt;
    logic [2:0] swcnt_r, swcnt_nxt;
    logic swrst_go;
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt, wr_fire;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, wmask, rd_val;
    logic rd_ok, wr_ok;
    logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
    logic [1:0] bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    logic wake_nxt, rst_out_nxt, usb_nxt, irq_nxt;
    logic [5:0] wr_cause_clr, wr_istat_clr;

    // event edges: third stage only compares after the two-flop synchroniser
    always_comb begin
        src_a_nxt = {RST_REG_FAULT, RST_WATCHDOG, RST_BROWN_OUT, RST_EXT_PIN};
        src_b_nxt = src_a_r;
        src_c_nxt = src_b_r;
        ev = '0;
        ev[sysrc_pkg::cause_external_pin] = src_b_r[0] & ~src_c_r[0];
        ev[sysrc_pkg::cause_brown_out] = src_b_r[1] & ~src_c_r[1];
        ev[sysrc_pkg::cause_watchdog_expiry] = src_b_r[2] & ~src_c_r[2];
        ev[sysrc_pkg::cause_regulator_fault] = src_b_r[3] & ~src_c_r[3];
        ev[sysrc_pkg::cause_software_request] = swrst_go;
    end

    // divided pwm clock
    always_comb begin
        mask6 = 6'((7'h01 << sel_r) - 7'h01);
        tick = (cnt_r == mask6);
        cnt_nxt = tick ? 6'h00 : 6'(cnt_r + 6'h01);
        sel_nxt = tick ? pwmdiv_r : sel_r;
    end

    // bus slave and register file
    always_comb begin
        wmask = {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
        aw_full_nxt = aw_full_r | (AWVALID & AWREADY);
        w_full_nxt = w_full_r | (WVALID & WREADY);
        awaddr_nxt = (AWVALID & AWREADY) ? AWADDR : awaddr_r;
        wdata_nxt = (WVALID & WREADY) ? (WDATA & wmask) : wdata_r;
        wr_fire = aw_full_r & w_full_r & ~BVALID;
        bvalid_nxt = BVALID & ~BREADY;
        bresp_nxt = BRESP;
        ctrl_nxt = ctrl_r;
        pwmdiv_nxt = pwmdiv_r;
        runen_nxt = runen_r;
        slpen_nxt = slpen_r;
        imask_nxt = imask_r;
        wr_cause_clr = '0;
        wr_istat_clr = '0;
        swrst_go = 1'b0;
        wr_ok = 1'b1;
        if (wr_fire) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            case (awaddr_r)
                sysrc_pkg::OFF_CTRL: begin
                    ctrl_nxt = wdata_r[1:0];
                    swrst_go = wdata_r[sysrc_pkg::CTRL_SWRST];
                end
                sysrc_pkg::OFF_PWMDIV: begin
                    if (wdata_r[2:0] <= sysrc_pkg::pwm_clock_ratio_sixty_four) begin
                        pwmdiv_nxt = wdata_r[2:0];
                    end
                end
                sysrc_pkg::OFF_CAUSE: wr_cause_clr = wdata_r[5:0];
                sysrc_pkg::OFF_RUNEN: runen_nxt = wdata_r[N_PERIPH-1:0];
                // marking kept regardless of gating mode
                sysrc_pkg::OFF_SLPEN: slpen_nxt = wdata_r[N_PERIPH-1:0];
                sysrc_pkg::OFF_ISTAT: wr_istat_clr = wdata_r[5:0];
                sysrc_pkg::OFF_IMASK: imask_nxt = wdata_r[5:0];
                sysrc_pkg::OFF_SRAM, sysrc_pkg::OFF_STAT: wr_ok = 1'b1;
                default: wr_ok = 1'b0;
            endcase
            bresp_nxt = wr_ok ? sysrc_pkg::RESP_OKAY : sysrc_pkg::RESP_SLVERR;
        end
        if (swrst_go) begin
            ctrl_nxt = sysrc_pkg::CTRL_RST;
            pwmdiv_nxt = sysrc_pkg::PWMDIV_RST;
            runen_nxt = '0;
            slpen_nxt = '0;
            imask_nxt = '0;
        end
        // external reset wipes the record, then sets win over clears
        cause_nxt = ev[sysrc_pkg::cause_external_pin] ? 6'h00 : (cause_r & ~wr_cause_clr);
        cause_nxt = cause_nxt | ev;
        istat_nxt = (swrst_go ? 6'h00 : (istat_r & ~wr_istat_clr)) | ev;
        awready_nxt = ~aw_full_nxt;
        wready_nxt = ~w_full_nxt;
        rd_val = '0;
        rd_ok = 1'b1;
        case (ARADDR)
            sysrc_pkg::OFF_CTRL: rd_val[1:0] = ctrl_r;
            sysrc_pkg::OFF_PWMDIV: rd_val[2:0] = pwmdiv_r;
            sysrc_pkg::OFF_CAUSE: rd_val[5:0] = cause_r;
            sysrc_pkg::OFF_RUNEN: rd_val[N_PERIPH-1:0] = runen_r;
            sysrc_pkg::OFF_SLPEN: rd_val[N_PERIPH-1:0] = slpen_r;
            sysrc_pkg::OFF_SRAM: rd_val = SRAM_BYTES;
            sysrc_pkg::OFF_ISTAT: rd_val[5:0] = istat_r;
            sysrc_pkg::OFF_IMASK: rd_val[5:0] = imask_r;
            sysrc_pkg::OFF_STAT: rd_val[2:0] = {CPU_SLEEP, USB_PLL_PWR, SYS_RST_OUT};
            default: rd_ok = 1'b0;
        endcase
        rvalid_nxt = RVALID & ~RREADY;
        rdata_nxt = RDATA;
        rresp_nxt = RRESP;
        if (ARVALID & ARREADY) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_val;
            rresp_nxt = rd_ok ? sysrc_pkg::RESP_OKAY : sysrc_pkg::RESP_SLVERR;
        end
        arready_nxt = ~rvalid_nxt;
    end

    // outputs toward the rest of the chip
    always_comb begin
        clken_nxt = runen_r & ((CPU_SLEEP & ctrl_r[sysrc_pkg::CTRL_AUTOGATE]) ?
                               slpen_r : {N_PERIPH{1'b1}});
        wake_nxt = CPU_SLEEP & |(PERIPH_IRQ & PERIPH_CLK_EN);
        usb_nxt = ctrl_r[sysrc_pkg::CTRL_USBPLL];
        irq_nxt = |(istat_r & imask_r);
        swcnt_nxt = swcnt_r;
        if (swrst_go) begin
            swcnt_nxt = 3'(sysrc_pkg::SWRST_CYCLES);
        end else if (swcnt_r != 3'h0) begin
            swcnt_nxt = 3'(swcnt_r - 3'h1);
        end
        rst_out_nxt = (swcnt_nxt != 3'h0);
    end

    always_ff @(posedge CLOCK) begin
        src_a_r <= src_a_nxt;
        src_b_r <= src_b_nxt;
        src_c_r <= src_c_nxt;
        if (SRST) begin
            ctrl_r <= sysrc_pkg::CTRL_RST;
            pwmdiv_r <= sysrc_pkg::PWMDIV_RST;
            sel_r <= sysrc_pkg::PWMDIV_RST;
            cnt_r <= 6'h00;
            // power-on leaves only its own bit
            cause_r <= sysrc_pkg::CAUSE_RST;
            istat_r <= 6'h00;
            imask_r <= 6'h00;
            runen_r <= '0;
            slpen_r <= '0;
            swcnt_r <= 3'h0;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= 2'h0;
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= 2'h0;
            PERIPH_CLK_EN <= '0;
            WAKE_REQ <= 1'b0;
            SYS_RST_OUT <= 1'b0;
            PWM_CLK_EN <= 1'b0;
            USB_PLL_PWR <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            pwmdiv_r <= pwmdiv_nxt;
            sel_r <= sel_nxt;
            cnt_r <= cnt_nxt;
            cause_r <= cause_nxt;
            istat_r <= istat_nxt;
            imask_r <= imask_nxt;
            runen_r <= runen_nxt;
            slpen_r <= slpen_nxt;
            swcnt_r <= swcnt_nxt;
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            AWREADY <= awready_nxt;
            WREADY <= wready_nxt;
            BVALID <= bvalid_nxt;
            BRESP <= bresp_nxt;
            ARREADY <= arready_nxt;
            RVALID <= rvalid_nxt;
            RDATA <= rdata_nxt;
            RRESP <= rresp_nxt;
            PERIPH_CLK_EN <= clken_nxt;
            WAKE_REQ <= wake_nxt;
            SYS_RST_OUT <= rst_out_nxt;
            // tick pulses once every 2^sel_r system clocks
            PWM_CLK_EN <= tick;
            USB_PLL_PWR <= usb_nxt;
            IRQ <= irq_nxt;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    a_pwm_code_legal: assert property (pwmdiv_r <= 3'h6)
        else $error("divider code out of range");
    a_pwm_ratio_two: assert property (tick && sel_r == 3'h1 && pwmdiv_r == 3'h1
        |=> !tick ##1 tick)
        else $error("ratio two period wrong");
    a_switch_boundary: assert property (sel_r != $past(sel_r) |-> $past(tick))
        else $error("divider switched off boundary");
    a_sw_cause_kept: assert property (swrst_go && ev[3:0] == 4'h0 && ev[5] == 1'b0
        |=> cause_r == ($past(cause_r) | 6'h10))
        else $error("software reset disturbed the cause record");
    a_ext_wipes: assert property (ev == 6'h01 |=> cause_r == 6'h01)
        else $error("external reset did not reset the record");
    a_clear_subset: assert property (wr_cause_clr != 6'h00 && ev == 6'h00
        |=> cause_r == $past(cause_r & ~wr_cause_clr))
        else $error("clear touched unnamed causes");
    a_gate_sleep: assert property (CPU_SLEEP && ctrl_r[0]
        |=> PERIPH_CLK_EN == $past(runen_r & slpen_r))
        else $error("sleep gating wrong");
    a_gate_noauto: assert property (!ctrl_r[0]
        |=> PERIPH_CLK_EN == $past(runen_r))
        else $error("enabled peripheral lost clock");
    a_usb_follow: assert property (!ctrl_r[1] |=> !USB_PLL_PWR)
        else $error("usb pll powered while off");
    a_swrst_len: assert property ($rose(SYS_RST_OUT) |-> SYS_RST_OUT [*5] ##1 !SYS_RST_OUT)
        else $error("software reset pulse length wrong");
    a_irq_level: assert property (##1 IRQ == $past(|(istat_r & imask_r)))
        else $error("interrupt level wrong");

    c_swrst: cover property (swrst_go ##6 !SYS_RST_OUT);
    c_ratio_64: cover property (sel_r == 3'h6 && tick);
    c_sleep_wake: cover property (CPU_SLEEP && ctrl_r[0] ##1 WAKE_REQ);
    c_two_causes: cover property (cause_r[3] && cause_r[2]);
endmodule // sysrc_ctrl

// ### logic/sysrc_pkg.sv
package sysrc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PWMDIV = 8'h04;
    localparam logic [7:0] OFF_CAUSE = 8'h08;
    localparam logic [7:0] OFF_RUNEN = 8'h0c;
    localparam logic [7:0] OFF_SLPEN = 8'h10;
    localparam logic [7:0] OFF_SRAM = 8'h14;
    localparam logic [7:0] OFF_ISTAT = 8'h18;
    localparam logic [7:0] OFF_IMASK = 8'h1c;
    localparam logic [7:0] OFF_STAT = 8'h20;
    // control fields
    localparam int CTRL_AUTOGATE = 0;
    localparam int CTRL_USBPLL = 1;
    localparam int CTRL_SWRST = 2;
    localparam logic [1:0] CTRL_RST = 2'h0;
    // reset-cause bit positions, shared by cause, status and mask
    localparam int N_CAUSES = 6;
    localparam int cause_external_pin = 0;
    localparam int cause_power_on = 1;
    localparam int cause_brown_out = 2;
    localparam int cause_watchdog_expiry = 3;
    localparam int cause_software_request = 4;
    localparam int cause_regulator_fault = 5;
    localparam logic [5:0] CAUSE_RST = 6'h02;
    // divider ratio encodings: ratio is two to the power of the code
    localparam logic [2:0] pwm_clock_ratio_one = 3'h0;
    localparam logic [2:0] pwm_clock_ratio_two = 3'h1;
    localparam logic [2:0] pwm_clock_ratio_four = 3'h2;
    localparam logic [2:0] pwm_clock_ratio_eight = 3'h3;
    localparam logic [2:0] pwm_clock_ratio_sixteen = 3'h4;
    localparam logic [2:0] pwm_clock_ratio_thirty_two = 3'h5;
    localparam logic [2:0] pwm_clock_ratio_sixty_four = 3'h6;
    localparam logic [2:0] PWMDIV_RST = pwm_clock_ratio_one;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SWRST_TIME_NS = 20;
    localparam int SWRST_CYCLES = (SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### test/system_reset_clock_control_bench.sv
`timescale 1ns/1ns
module system_reset_clock_control_bench;
    logic clock, srst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cpu_sleep, wake_req, sys_rst_out;
    logic pwm_clk_en, usb_pll_pwr, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, periph_irq, periph_clk_en;
    logic [3:0] wstrb, src;
    logic [1:0] bresp, rresp, resp;
    int err_total, comparisons, cycles, rst_hi, p;

    sysrc_ctrl DUT (
        .CLOCK(clock), .SRST(srst), .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb), .BVALID(bvalid),
        .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready),
        .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
        .RST_EXT_PIN(src[0]), .RST_BROWN_OUT(src[1]), .RST_WATCHDOG(src[2]),
        .RST_REG_FAULT(src[3]), .CPU_SLEEP(cpu_sleep), .PERIPH_IRQ(periph_irq),
        .PERIPH_CLK_EN(periph_clk_en), .WAKE_REQ(wake_req), .SYS_RST_OUT(sys_rst_out),
        .PWM_CLK_EN(pwm_clk_en), .USB_PLL_PWR(usb_pll_pwr), .IRQ(irq)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // hang guard: the whole sequence needs about a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (sys_rst_out === 1'b1) rst_hi++;
        if (cycles == 20000) begin
            err_total++;
            $display("[FAIL] %0t run did not finish", $time);
            give_verdict();
        end
    end

    task give_verdict();
        $display("counts: %0d compared, %0d mismatched", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
        end while (!(bvalid === 1'b1 && bready) && n < 100);
        resp = bresp;
        bready <= 1'b0;
        if (n >= 100) chk_bit(1'b0, 1'b1, "write answer");
    endtask

    task rd_reg(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clock);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        end while (!(rvalid === 1'b1 && rready) && n < 100);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n >= 100) chk_bit(1'b0, 1'b1, "read answer");
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd_reg(a);
        chk_word(rd, exp, what);
    endtask

    // a reset source held for three cycles, then time for the synchroniser
    task pulse(input int b);
        @(posedge clock);
        src[b] <= 1'b1;
        tick(3);
        src[b] <= 1'b0;
        tick(8);
    endtask

    task pwm_period(output int per);
        int n;
        n = 0;
        per = 0;
        @(posedge clock);
        while (pwm_clk_en !== 1'b1 && n < 200) begin
            @(posedge clock);
            n++;
        end
        do begin
            @(posedge clock);
            per++;
        end while (pwm_clk_en !== 1'b1 && per < 200);
    endtask

    task done(input string name);
        $display("test %s finished, %0d mismatches so far", name, err_total);
    endtask

    initial begin
        srst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, cpu_sleep} = '0;
        {awaddr, araddr, wdata, periph_irq, src} = '0;
        wstrb = 4'hf;
        tick(4);
        srst <= 1'b0;
        rchk(sysrc_pkg::OFF_CAUSE, 32'h00000002, "power-on cause");
        rchk(sysrc_pkg::OFF_SRAM, 32'h00010000, "sram size");
        rchk(sysrc_pkg::OFF_PWMDIV, 32'h0, "divider default");
        done("reset");
        for (int c = 0; c < 7; c++) begin
            wr(sysrc_pkg::OFF_PWMDIV, 32'(c));
            rchk(sysrc_pkg::OFF_PWMDIV, 32'(c), "divider code");
            // the first period may still run at the old ratio
            pwm_period(p);
            pwm_period(p);
            chk_word(32'(p), 32'h1 << c, "pwm period");
        end
        wr(sysrc_pkg::OFF_PWMDIV, 32'h7);
        rchk(sysrc_pkg::OFF_PWMDIV, 32'h6, "illegal code kept out");
        done("divider");
        pulse(2);
        rchk(sysrc_pkg::OFF_CAUSE, 32'h0000000a, "watchdog adds");
        pulse(1);
        pulse(3);
        rchk(sysrc_pkg::OFF_CAUSE, 32'h0000002e, "causes accumulate");
        wr(sysrc_pkg::OFF_CAUSE, 32'h8);
        rchk(sysrc_pkg::OFF_CAUSE, 32'h00000026, "subset clear");
        pulse(2);
        rchk(sysrc_pkg::OFF_CAUSE, 32'h0000002e, "cleared cause sets again");
        wr(sysrc_pkg::OFF_CAUSE, 32'h3f);
        rchk(sysrc_pkg::OFF_CAUSE, 32'h0, "clear all");
        pulse(2);
        pulse(0);
        rchk(sysrc_pkg::OFF_CAUSE, 32'h00000001, "external wipes record");
        done("cause");
        pulse(2);
        wr(sysrc_pkg::OFF_PWMDIV, 32'h3);
        wr(sysrc_pkg::OFF_CTRL, 32'h3);
        wr(sysrc_pkg::OFF_RUNEN, 32'hff);
        wr(sysrc_pkg::OFF_IMASK, 32'h3f);
        rst_hi = 0;
        wr(sysrc_pkg::OFF_CTRL, 32'h4);
        tick(20);
        chk_word(32'(rst_hi), 32'(sysrc_pkg::SWRST_CYCLES), "reset pulse");
        rchk(sysrc_pkg::OFF_CTRL, 32'h0, "ctrl default");
        rchk(sysrc_pkg::OFF_PWMDIV, 32'h0, "divider default");
        rchk(sysrc_pkg::OFF_RUNEN, 32'h0, "run enables default");
        rchk(sysrc_pkg::OFF_IMASK, 32'h0, "mask default");
        rchk(sysrc_pkg::OFF_CAUSE, 32'h00000019, "cause kept plus software");
        done("software reset");
        wr(sysrc_pkg::OFF_ISTAT, 32'h3f);
        wr(sysrc_pkg::OFF_IMASK, 32'h4);
        pulse(1);
        chk_bit(irq, 1'b1, "irq raised");
        wr(sysrc_pkg::OFF_IMASK, 32'h0);
        tick(3);
        chk_bit(irq, 1'b0, "irq masked");
        wr(sysrc_pkg::OFF_IMASK, 32'h4);
        tick(3);
        chk_bit(irq, 1'b1, "irq unmasked");
        wr(sysrc_pkg::OFF_ISTAT, 32'h4);
        tick(3);
        chk_bit(irq, 1'b0, "irq cleared");
        done("interrupt");
        wr(sysrc_pkg::OFF_RUNEN, 32'hff);
        wr(sysrc_pkg::OFF_SLPEN, 32'h0f);
        cpu_sleep <= 1'b1;
        tick(3);
        chk_word(periph_clk_en, 32'hff, "sleep without gating");
        wr(sysrc_pkg::OFF_CTRL, 32'h1);
        tick(3);
        chk_word(periph_clk_en, 32'h0f, "sleep with gating");
        periph_irq <= 32'h40;
        tick(3);
        chk_bit(wake_req, 1'b0, "gated peripheral no wake");
        periph_irq <= 32'h04;
        tick(3);
        chk_bit(wake_req, 1'b1, "clocked peripheral wakes");
        periph_irq <= 32'h0;
        wr(sysrc_pkg::OFF_CTRL, 32'h0);
        tick(3);
        chk_word(periph_clk_en, 32'hff, "gating off again");
        rchk(sysrc_pkg::OFF_SLPEN, 32'h0f, "sleep marking kept");
        cpu_sleep <= 1'b0;
        done("gating");
        wr(sysrc_pkg::OFF_CTRL, 32'h2);
        tick(2);
        chk_bit(usb_pll_pwr, 1'b1, "pll powered");
        rchk(sysrc_pkg::OFF_STAT, 32'h2, "status pll");
        wr(sysrc_pkg::OFF_CTRL, 32'h0);
        tick(2);
        chk_bit(usb_pll_pwr, 1'b0, "pll down");
        done("usb");
        wr(8'h40, 32'h1);
        chk_word(32'(resp), 32'(sysrc_pkg::RESP_SLVERR), "unmapped write");
        rd_reg(8'h40);
        chk_word(32'(resp), 32'(sysrc_pkg::RESP_SLVERR), "unmapped read");
        wr(sysrc_pkg::OFF_SRAM, 32'h0);
        rchk(sysrc_pkg::OFF_SRAM, 32'h00010000, "sram read-only");
        done("bus");
        give_verdict();
    end
endmodule // system_reset_clock_control_bench
